//--- rtl/bbs_map.svh
`ifndef BBS_MAP_SVH
`define BBS_MAP_SVH

// opcode patterns
`define BBS_OP_BNNEG   8'he7
`define BBS_OP_BNOVF   8'he5
`define BBS_OP_BNZERO  8'he1
`define BBS_OP_BALW    5'h1a
`define BBS_OP_BSET    4'h8
// field positions
`define BBS_HI_MSB     15
`define BBS_HI_LSB     8
`define BBS_BALW_LSB   11
`define BBS_BSET_LSB   12
`define BBS_BIT_MSB    11
`define BBS_BIT_LSB    9
`define BBS_ACC_BIT    8
`define BBS_OFF8_MSB   7
`define BBS_OFF11_MSB  10
// access bank split: low addresses go to bank 0, upper half to the top bank
`define BBS_ACC_SPLIT  8'h80
`define BBS_ACC_HIBANK 4'hf
// quarter phase codes
`define BBS_Q1         2'h0
`define BBS_Q2         2'h1
`define BBS_Q3         2'h2
`define BBS_Q4         2'h3
// program counter reset value
`define BBS_PC_RST     21'h000000

`endif

//--- rtl/bbs_pkg.sv
package bbs_pkg;
  // instruction classes seen by the decoder
  typedef enum logic [5:0] {
    BBS_I_NONE  = 6'h01,
    BBS_I_BNNEG = 6'h02,
    BBS_I_BNOVF = 6'h04,
    BBS_I_BNZER = 6'h08,
    BBS_I_BALW  = 6'h10,
    BBS_I_BSET  = 6'h20
  } bbs_instr_e;

  // execution cycle states
  typedef enum logic [1:0] {
    BBS_S_EXEC = 2'h1,
    BBS_S_NOP  = 2'h2
  } bbs_state_e;
endpackage : bbs_pkg

//--- rtl/bbs_quarter.sv
`timescale 1ns/10ps
`include "bbs_map.svh"

// quarter phase counter: q1..q4 then wraps, reset starts it in q1
module bbs_quarter (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  output logic [1:0]      phase_o
);
  logic [1:0] phase_q;  // current quarter
  logic [1:0] phase_d;  // next quarter

  // next quarter
  always_comb begin
    phase_d = phase_q + 2'h1;
  end

  // register quarter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= `BBS_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase_o = phase_q;
endmodule : bbs_quarter

//--- rtl/bbs_decode.sv
`timescale 1ns/10ps
`include "bbs_map.svh"

////////////////////////////////////////////////////////////////////////////
// timing overview, one instruction cycle is four clock edges
//
// q1 edge: pc steps past the word being executed
// q2 edge: branch condition frozen, file read strobe raised
// q3 edge: branch target formed, file data captured
// q4 edge: pc loaded if taken, write strobe, next word latched
//
// after a taken branch one whole cycle does nothing
// the word latched at the end of that idle cycle sits at the target
// so the idle cycle doubles as the refetch slot
//
// after reset the first cycle is idle as well
// this gives the memory one cycle to present the word at address zero
// and avoids executing whatever stood on the bus during reset
//
// unknown opcodes fall through as a plain pc step
// they raise no file strobe and never touch the program counter otherwise
//
// hazards a user must know:
// - flags are read combinationally in q2, keep them steady there
// - file read data must settle before the q3 edge
// - the instruction word must settle before the q4 edge
// - bank select is read with the address in q2 only
//
// trade-offs:
// - target adder runs in every q3 of an exec cycle, even for non-branches, keeps decode flat
// - write data is built from the captured value, not from the live bus
// - the quarter counter free-runs, only reset realigns it
////////////////////////////////////////////////////////////////////////////

module bbs_decode
  import bbs_pkg::*;
#(
  parameter int PC_W = 21  // program counter width
) (
  input  wire logic            CLOCK_I,
  input  wire logic            RST_I,
  input  wire logic [15:0]     INSTR_I,        // fetched instruction word
  input  wire logic            FLAG_NEG_I,     // negative flag from status
  input  wire logic            FLAG_OVF_I,     // overflow flag from status
  input  wire logic            FLAG_ZERO_I,    // zero flag from status
  input  wire logic [3:0]      BANK_SEL_I,     // bank select register
  input  wire logic [7:0]      FILE_RDATA_I,   // register file read data
  output logic [PC_W-1:0]      PC_O,           // program counter
  output logic [1:0]           QPHASE_O,       // quarter, registered one clock behind the quarter counter
  output logic                 FETCH_O,        // fetch strobe, q4 of a cycle
  output logic                 FILE_RD_O,      // register read strobe
  output logic                 FILE_WR_O,      // register write strobe
  output logic [11:0]          FILE_ADDR_O,    // banked register address
  output logic [7:0]           FILE_WDATA_O,   // register write data
  output logic                 NOP_CYCLE_O     // idle cycle after a taken branch or reset
);

  ////////////////////////////////////////////////////////////////////////////
  // quarter phases

  logic [1:0] phase;  // current quarter

  bbs_quarter u_quarter (
    .clk_i   (CLOCK_I),
    .rst_i   (RST_I),
    .phase_o (phase)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode, combinational from the latched word

  logic [15:0]     ir_q;       // instruction register
  logic [15:0]     ir_d;
  bbs_instr_e      cls;        // decoded class
  logic            cond_ok;    // branch condition holds
  logic [PC_W-1:0] offs;       // sign-extended offset
  logic [2:0]      bit_idx;    // bit index for set
  logic [11:0]     faddr;      // banked file address

  // classify instruction
  always_comb begin
    cls = BBS_I_NONE;
    if (ir_q[`BBS_HI_MSB:`BBS_HI_LSB] == `BBS_OP_BNNEG) begin
      cls = BBS_I_BNNEG;
    end else if (ir_q[`BBS_HI_MSB:`BBS_HI_LSB] == `BBS_OP_BNOVF) begin
      cls = BBS_I_BNOVF;
    end else if (ir_q[`BBS_HI_MSB:`BBS_HI_LSB] == `BBS_OP_BNZERO) begin
      cls = BBS_I_BNZER;
    end else if (ir_q[`BBS_HI_MSB:`BBS_BALW_LSB] == `BBS_OP_BALW) begin
      cls = BBS_I_BALW;
    end else if (ir_q[`BBS_HI_MSB:`BBS_BSET_LSB] == `BBS_OP_BSET) begin
      cls = BBS_I_BSET;
    end
  end

  // condition and offset; flags only read, never written
  always_comb begin
    cond_ok = 1'b0;
    offs    = '0;
    case (cls)
      BBS_I_BNNEG: cond_ok = ~FLAG_NEG_I;
      BBS_I_BNOVF: cond_ok = ~FLAG_OVF_I;
      BBS_I_BNZER: cond_ok = ~FLAG_ZERO_I;
      BBS_I_BALW:  cond_ok = 1'b1;
      default:     cond_ok = 1'b0;
    endcase
    if (cls == BBS_I_BALW) begin
      // 11-bit signed offset, -1024..1023
      offs = PC_W'($signed(ir_q[`BBS_OFF11_MSB:0]));
    end else begin
      // 8-bit signed offset, -128..127
      offs = PC_W'($signed(ir_q[`BBS_OFF8_MSB:0]));
    end
  end

  // bit-set address: access bank or bank select
  always_comb begin
    bit_idx = ir_q[`BBS_BIT_MSB:`BBS_BIT_LSB];
    if (ir_q[`BBS_ACC_BIT]) begin
      faddr = {BANK_SEL_I, ir_q[7:0]};
    end else if (ir_q[7:0] < `BBS_ACC_SPLIT) begin
      faddr = {4'h0, ir_q[7:0]};
    end else begin
      faddr = {`BBS_ACC_HIBANK, ir_q[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state
  //
  // exec state: the latched word runs through its four quarters
  // nop state: forced idle cycle after a taken branch or reset
  //
  // strobes are cleared every quarter by default
  // so each one stands exactly one clock after its edge
  //
  // address and write data hold until the next bit-set
  // so the register file may sample them late
  //
  // take flag is cleared in q1 and set in q2
  // a stale decision can never reach the q4 pc write
  //
  // the captured file value is kept apart from the write data
  // the set is applied in q4, one edge after the capture
  // the write data then stands together with the write strobe
  //
  // pc step and pc load never fall in one quarter
  // q1 only steps, q4 only loads
  // so no priority between them is needed
  //
  // the word latched in q4 of a taken branch is the one after it
  // it is discarded by the idle cycle that follows
  // and the word at the target replaces it at the end of that cycle
  //
  // no status flag is written anywhere in this block
  bbs_state_e      st_q, st_d;       // exec or forced nop cycle
  logic [PC_W-1:0] pc_q, pc_d;       // program counter
  logic            fetch_q, fetch_d;
  logic            rd_q, rd_d;
  logic            wr_q, wr_d;
  logic [11:0]     addr_q, addr_d;
  logic [7:0]      wdat_q, wdat_d;
  logic [7:0]      rdat_q, rdat_d;   // register value latched in q3
  logic [PC_W-1:0] tgt_q, tgt_d;     // target computed in q3
  logic            take_q, take_d;   // branch taken this cycle

  // next state per quarter
  always_comb begin
    st_d    = st_q;
    pc_d    = pc_q;
    ir_d    = ir_q;
    fetch_d = 1'b0;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    rdat_d  = rdat_q;
    tgt_d   = tgt_q;
    take_d  = take_q;
    case (phase)
      `BBS_Q1: begin
        // decode; pc steps past this word at the q1 edge
        if (st_q == BBS_S_EXEC) begin
          pc_d = pc_q + PC_W'(2);
        end
        take_d = 1'b0;
      end
      `BBS_Q2: begin
        // freeze branch condition, or read the file register
        if (st_q == BBS_S_EXEC) begin
          take_d = cond_ok;
          if (cls == BBS_I_BSET) begin
            rd_d   = 1'b1;
            addr_d = faddr;
          end
        end
      end
      `BBS_Q3: begin
        // process data
        if (st_q == BBS_S_EXEC) begin
          tgt_d  = pc_q + (offs << 1);
          rdat_d = FILE_RDATA_I;
        end
      end
      `BBS_Q4: begin
        // write pc or register, fetch next word
        fetch_d = 1'b1;
        if (st_q == BBS_S_EXEC) begin
          if (take_q) begin
            pc_d = tgt_q;
            st_d = BBS_S_NOP;
          end
          if (cls == BBS_I_BSET) begin
            wr_d   = 1'b1;
            wdat_d = rdat_q | (8'h01 << bit_idx);
          end
          ir_d = INSTR_I;
        end else begin
          // nop cycle done, refetched word at target
          st_d = BBS_S_EXEC;
          ir_d = INSTR_I;
        end
      end
      default: begin
        st_d = BBS_S_EXEC;
      end
    endcase
  end

  // register state
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q    <= BBS_S_NOP;
      pc_q    <= `BBS_PC_RST;
      ir_q    <= 16'hffff;
      fetch_q <= 1'b0;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= 12'h000;
      wdat_q  <= 8'h00;
      rdat_q  <= 8'h00;
      tgt_q   <= `BBS_PC_RST;
      take_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      pc_q    <= pc_d;
      ir_q    <= ir_d;
      fetch_q <= fetch_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      rdat_q  <= rdat_d;
      tgt_q   <= tgt_d;
      take_q  <= take_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  logic [1:0] qph_q;  // registered copy of the quarter
  logic       nop_q;  // registered nop-cycle flag

  // register phase and nop indication
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      qph_q <= `BBS_Q1;
      nop_q <= 1'b0;
    end else begin
      qph_q <= phase;
      nop_q <= (st_q == BBS_S_NOP);
    end
  end

  assign PC_O         = pc_q;
  assign QPHASE_O     = qph_q;
  assign FETCH_O      = fetch_q;
  assign FILE_RD_O    = rd_q;
  assign FILE_WR_O    = wr_q;
  assign FILE_ADDR_O  = addr_q;
  assign FILE_WDATA_O = wdat_q;
  assign NOP_CYCLE_O  = nop_q;

endmodule : bbs_decode

//--- verif/bbs_decode_asserts.sv
`timescale 1ns/10ps
// port checks for the decoder
module bbs_decode_asserts #(
  parameter int PC_W = 21  // pc width
) (
  input wire logic            CLOCK_I,
  input wire logic            RST_I,
  input wire logic [7:0]      FILE_RDATA_I,
  input wire logic [PC_W-1:0] PC_O,
  input wire logic [1:0]      QPHASE_O,
  input wire logic            FETCH_O,
  input wire logic            FILE_RD_O,
  input wire logic            FILE_WR_O,
  input wire logic [7:0]      FILE_WDATA_O,
  input wire logic            NOP_CYCLE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////////////////////////
  a_fetch_period: assert property (FETCH_O |=> !FETCH_O [*3] ##1 FETCH_O)
    else $error("fetch not every four clocks");
  a_wr_follow: assert property (FILE_RD_O |-> ##2 FILE_WR_O)
    else $error("write not two clocks after read");
  a_wdata_bit: assert property (FILE_WR_O |-> (FILE_WDATA_O & $past(FILE_RDATA_I, 2)) ==
    $past(FILE_RDATA_I, 2) && $countones(FILE_WDATA_O ^ $past(FILE_RDATA_I, 2)) <= 1)
    else $error("write data not read data plus one bit");
  a_nop_len: assert property ($rose(NOP_CYCLE_O) && !$past(RST_I, 5) |->
    NOP_CYCLE_O [*4] ##1 !NOP_CYCLE_O)
    else $error("no-op cycle not four clocks");
  a_nop_quiet: assert property (NOP_CYCLE_O |-> !FILE_RD_O && !FILE_WR_O)
    else $error("file access in no-op cycle");
  a_phase_step: assert property (QPHASE_O != $past(QPHASE_O) |-> QPHASE_O == $past(QPHASE_O) + 2'h1)
    else $error("quarter skipped");
  a_phase_wrap: assert property (QPHASE_O == 2'h3 |=> QPHASE_O == 2'h0)
    else $error("quarter did not wrap");
  a_pc_even: assert property (PC_O[0] == 1'b0)
    else $error("pc odd");
  // main scenarios reached
  c_wr: cover property (FILE_RD_O ##2 FILE_WR_O);
  c_nop: cover property ($rose(NOP_CYCLE_O));
  c_fetch: cover property (FETCH_O);
endmodule : bbs_decode_asserts

//--- verif/bbs_mem_model.sv
`timescale 1ns/10ps
// program memory and register file seen by the decoder
module bbs_mem_model (
  input  wire logic        clk_i,
  input  wire logic [20:0] pc_i,
  output logic      [15:0] instr_o,
  input  wire logic        wr_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  logic [15:0] prog [2048];  // word memory, byte pc
  logic [7:0]  regs [4096];  // banked registers
  assign instr_o = prog[pc_i[11:1]];
  assign rdata_o = regs[addr_i];
  // register write on the strobe
  always @(posedge clk_i) begin
    if (wr_i) begin
      regs[addr_i] <= wdata_i;
    end
  end
endmodule : bbs_mem_model

//--- verif/tb.sv
`timescale 1ns/10ps
// random branches, each with a skipped and a target bit-set
module tb;
  logic        clk;
  logic        rst;
  logic [2:0]  flg;    // neg, ovf, zero
  logic [3:0]  bank;   // bank select
  logic [20:0] pc;
  logic [15:0] instr;
  logic [7:0]  rdata, wdata;
  logic [11:0] addr;
  logic        wr;
  int          error_cnt, checks, cyc;
  logic [7:0]  ops [3] = '{8'he7, 8'he5, 8'he1};
  bbs_decode bbs_decode_inst (.CLOCK_I(clk), .RST_I(rst), .INSTR_I(instr), .FLAG_NEG_I(flg[2]),
    .FLAG_OVF_I(flg[1]), .FLAG_ZERO_I(flg[0]), .BANK_SEL_I(bank), .FILE_RDATA_I(rdata), .PC_O(pc),
    .QPHASE_O(), .FETCH_O(), .FILE_RD_O(), .FILE_WR_O(wr), .FILE_ADDR_O(addr), .FILE_WDATA_O(wdata),
    .NOP_CYCLE_O());
  bbs_mem_model bbs_mem_model_inst (.clk_i(clk), .pc_i(pc), .instr_o(instr), .wr_i(wr), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // branch kind k taken for flags f
  function automatic bit taken(input int k, input logic [2:0] f);
    return k == 3 || !f[2-k];
  endfunction : taken
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    int k, n, fa, fb;
    logic [2:0] b;
    logic [7:0] va, vb;
    logic [11:0] aa, ab;
    rst = 1;
    flg = 0;
    bank = 1;
    void'($urandom(32'h4b4f));
    for (int t = 0; t < 32; t++) begin
      k = t % 4;
      n = (k == 3) ? int'($urandom % 2048) - 1024 : int'($urandom % 256) - 128;
      if (t < 8) n = (t < 4) ? ((k == 3) ? 1023 : 127) : ((k == 3) ? -1024 : -128);
      if (n > -9 && n < 1) n = 9;
      fa = $urandom % 256;
      fb = $urandom % 256;
      b = 3'($urandom);
      @(posedge clk);
      #1 rst = 1;
      flg = 3'($urandom);
      bank = 4'(1 + $urandom % 14);
      for (int i = 0; i < 2048; i++) bbs_mem_model_inst.prog[i] = 16'hffff;
      for (int i = 0; i < 4096; i++) bbs_mem_model_inst.regs[i] = 8'($urandom);
      bbs_mem_model_inst.prog[0] = (k == 3) ? {5'h1a, 11'(n)} : {ops[k], 8'(n)};
      bbs_mem_model_inst.prog[1] = {4'h8, b, 1'b0, 8'(fa)};
      bbs_mem_model_inst.prog[11'(1 + n)] = {4'h8, ~b, 1'b1, 8'(fb)};
      aa = {(fa >= 128) ? 4'hf : 4'h0, 8'(fa)};
      ab = {bank, 8'(fb)};
      va = bbs_mem_model_inst.regs[aa];
      vb = bbs_mem_model_inst.regs[ab];
      repeat (10) @(posedge clk);
      #1 rst = 0;
      repeat (28) @(posedge clk);
      if (taken(k, flg)) begin
        chk("skipped", bbs_mem_model_inst.regs[aa], va);
        chk("target", bbs_mem_model_inst.regs[ab], vb | (8'h1 << ~b));
      end else begin
        chk("fallthru", bbs_mem_model_inst.regs[aa], va | (8'h1 << b));
      end
      $display("test %0d done", t);
    end
    print_verdict();
  end
endmodule : tb
bind bbs_decode bbs_decode_asserts #(.PC_W(PC_W)) bbs_decode_asserts_inst (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .FILE_RDATA_I(FILE_RDATA_I), .PC_O(PC_O), .QPHASE_O(QPHASE_O), .FETCH_O(FETCH_O), .FILE_RD_O(FILE_RD_O),
  .FILE_WR_O(FILE_WR_O), .FILE_WDATA_O(FILE_WDATA_O), .NOP_CYCLE_O(NOP_CYCLE_O));
